// file: rtl/csp_dev_end.sv
// Purpose: device end: request stream out with hint and parity sideband,
//          completion stream in with backpressure
// Assumes: request beats from the core side arrive on dev_* ports, same clock
// Notes: completion beats leave on out_* ports; discontinued packets are
//        marked nullified on their last beat
// Function
// - Data width is 64, 128 or 256
// - Bit 42 flags hint on first beat
// - Hint kind on bits 44:43
// - Steering value on bits 52:45
// - Bits 84:53 odd parity per byte
// - Unused parity bits held at zero
// - Completion data low bits meaningful only
// - User drives sideband while valid high
// - User marks last beat of packet
// - Keep contiguous, full except last beat
// - Ignore keep bits beyond width
// - Valid held through whole packet
// - Transfer only when valid and ready
// - User holds beat while ready low
// - User may overlap requests and completions
// - Start flag only on first beat
// - Discontinue nullifies the completion packet
`timescale 1ns/1ps
module csp_dev_end
   import csp_pkg::*;
#(
   parameter int DW = CSP_DW_DEFAULT
)(
   input  wire logic                clk,
   input  wire logic                rst_n,
   csp_link_if.dev_mp               lnk,
   input  wire logic [DW-1:0]       dev_req_word,
   input  wire logic                dev_req_valid,
   input  wire logic                dev_req_last,
   input  wire logic                dev_req_hint,
   input  wire logic [1:0]          dev_req_hint_kind,
   input  wire logic [7:0]          dev_req_steer,
   input  wire logic                dev_cpl_space,
   output logic [DW-1:0]            out_cpl_word,
   output logic [CSP_KEEP_MAX-1:0]  out_cpl_keep,
   output logic                     out_cpl_valid,
   output logic                     out_cpl_last,
   output logic                     out_cpl_nullify
);
   localparam int NB = DW / 8;
   localparam int NK = DW / 32;

   // Other widths would leave the parity and keep lanes half built
   generate
      if (DW != 64 && DW != 128 && DW != 256)
      begin : g_bad_dw
         $error("Data width must be 64, 128 or 256");
      end
   endgenerate

   logic [CSP_PAR_W-1:0]      par_w;
   logic                      first_w;
   logic                      hint_first_w;
   logic [1:0]                kind_w;
   logic [7:0]                steer_w;
   logic                      disc_d;
   logic                      cnull_d;
   logic [CSP_REQ_SIDE_W-1:0] side_d;
   logic [CSP_REQ_SIDE_W-1:0] side_q;
   logic [DW-1:0]             word_q;
   logic                      valid_q;
   logic                      last_q;
   logic                      in_pkt_q;
   logic                      ready_q;
   logic                      disc_q;
   logic                      xfer_w;
   logic                      disc_w;
   logic [CSP_KEEP_MAX-1:0]   keep_w;
   logic [DW-1:0]             cword_q;
   logic [CSP_KEEP_MAX-1:0]   ckeep_q;
   logic                      cvalid_q;
   logic                      clast_q;
   logic                      cnull_q;

   genvar gi;
   generate
      for (gi = 0; gi < CSP_PAR_W; gi++)
      begin : g_par
         if (gi < NB)
         begin : g_live
            assign par_w[gi] = ~^dev_req_word[gi*8 +: 8];
         end
         else
         begin : g_zero
            assign par_w[gi] = 1'b0;
         end
      end
      for (gi = 0; gi < CSP_KEEP_MAX; gi++)
      begin : g_keep
         if (gi < NK)
         begin : g_use
            assign keep_w[gi] = lnk.cpl_in_keep[gi];
         end
         else
         begin : g_drop
            assign keep_w[gi] = 1'b0;
         end
      end
   endgenerate

   // Start is any valid beat after a last beat, or the first after reset
   assign first_w      = dev_req_valid & ~in_pkt_q;
   assign hint_first_w = first_w & dev_req_hint;
   // Hint fields held at zero without a hint, so stale values never look live
   assign kind_w       = dev_req_hint ? dev_req_hint_kind : 2'h0;
   assign steer_w      = dev_req_hint ? dev_req_steer : 8'h00;

   always_comb
   begin
      side_d = '0;
      side_d[CSP_SOP_BIT] = first_w;
      side_d[CSP_HINT_PRES] = hint_first_w;
      side_d[CSP_HINT_KIND_HI:CSP_HINT_KIND_LO] = kind_w;
      side_d[CSP_STEER_HI:CSP_STEER_LO] = steer_w;
      side_d[CSP_PAR_HI:CSP_PAR_LO] = par_w;
   end

   // Request stream has no back-pressure; one beat per valid cycle
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         side_q  <= '0;
         word_q  <= '0;
         valid_q <= 1'b0;
         last_q  <= 1'b0;
      end
      else
      begin
         side_q  <= side_d;
         word_q  <= dev_req_word;
         valid_q <= dev_req_valid;
         last_q  <= dev_req_valid & dev_req_last;
      end
   end

   // Framing moves only on valid beats, so idle gaps inside a packet are safe
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         in_pkt_q <= 1'b0;
      end
      else if (dev_req_valid)
      begin
         in_pkt_q <= ~dev_req_last;
      end
   end

   assign lnk.req_out_word  = word_q;
   assign lnk.req_out_side  = side_q;
   assign lnk.req_out_valid = valid_q;
   assign lnk.req_out_last  = last_q;

   assign xfer_w = lnk.cpl_in_valid & ready_q;
   assign disc_w = disc_q | lnk.cpl_in_side[CSP_CPL_DISC_BIT];
   // Discontinue stays sticky to the last beat even if user logic drops it early
   assign disc_d  = lnk.cpl_in_last ? 1'b0 : disc_w;
   assign cnull_d = lnk.cpl_in_last & disc_w;

   // Ready registered from downstream space, so it lags space by one cycle
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ready_q  <= 1'b0;
         disc_q   <= 1'b0;
         cvalid_q <= 1'b0;
      end
      else
      begin
         ready_q  <= dev_cpl_space;
         cvalid_q <= xfer_w;
         if (xfer_w)
         begin
            disc_q <= disc_d;
         end
      end
   end

   // Beat contents load only on a transfer, so a stalled beat never leaks out
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cword_q <= '0;
         ckeep_q <= '0;
         clast_q <= 1'b0;
         cnull_q <= 1'b0;
      end
      else if (xfer_w)
      begin
         cword_q <= lnk.cpl_in_word;
         ckeep_q <= keep_w;
         clast_q <= lnk.cpl_in_last;
         cnull_q <= cnull_d;
      end
   end

   assign lnk.cpl_in_ready = ready_q;
   assign out_cpl_word     = cword_q;
   assign out_cpl_keep     = ckeep_q;
   assign out_cpl_valid    = cvalid_q;
   assign out_cpl_last     = clast_q;
   assign out_cpl_nullify  = cnull_q;
endmodule : csp_dev_end

// file: rtl/csp_link_if.sv
// Purpose: carrier joining the device end and the user end
// Assumes: clk shared by both ends
// Notes: request stream has no ready; completion stream is ready/valid
`timescale 1ns/1ps
interface csp_link_if
   import csp_pkg::*;
#(
   parameter int DW = CSP_DW_DEFAULT
);
   logic [DW-1:0]             req_out_word;
   logic [CSP_REQ_SIDE_W-1:0] req_out_side;
   logic                      req_out_valid;
   logic                      req_out_last;
   logic [DW-1:0]             cpl_in_word;
   logic [CSP_CPL_SIDE_W-1:0] cpl_in_side;
   logic                      cpl_in_last;
   logic [CSP_KEEP_MAX-1:0]   cpl_in_keep;
   logic                      cpl_in_valid;
   logic                      cpl_in_ready;

   modport dev_mp (
      output req_out_word, req_out_side, req_out_valid, req_out_last, cpl_in_ready,
      input  cpl_in_word, cpl_in_side, cpl_in_last, cpl_in_keep, cpl_in_valid
   );
   modport usr_mp (
      input  req_out_word, req_out_side, req_out_valid, req_out_last, cpl_in_ready,
      output cpl_in_word, cpl_in_side, cpl_in_last, cpl_in_keep, cpl_in_valid
   );
endinterface : csp_link_if

// file: rtl/csp_pkg.sv
// Purpose: shared constants for the completer stream port
// Assumes: one clock, both ends built from this package
// Notes: sideband field positions on the request and completion streams
package csp_pkg;
   localparam int CSP_DW_DEFAULT   = 256;
   localparam int CSP_REQ_SIDE_W   = 85;
   localparam int CSP_CPL_SIDE_W   = 33;
   localparam int CSP_SOP_BIT      = 40;
   localparam int CSP_HINT_PRES    = 42;
   localparam int CSP_HINT_KIND_LO = 43;
   localparam int CSP_HINT_KIND_HI = 44;
   localparam int CSP_STEER_LO     = 45;
   localparam int CSP_STEER_HI     = 52;
   localparam int CSP_PAR_LO       = 53;
   localparam int CSP_PAR_HI       = 84;
   localparam int CSP_PAR_W        = 32;
   localparam int CSP_CPL_DISC_BIT = 0;
   localparam int CSP_CPL_PAR_LO   = 1;
   localparam int CSP_CPL_PAR_HI   = 32;
   localparam int CSP_KEEP_MAX     = 8;
endpackage : csp_pkg

// file: rtl/csp_usr_end.sv
// Purpose: user end: watches requests, sends completion packets
// Assumes: completion beats come from a user source with its own ready
// Notes: a held beat is a register, so hold under back-pressure is natural
`timescale 1ns/1ps
module csp_usr_end
   import csp_pkg::*;
#(
   parameter int DW = CSP_DW_DEFAULT
)(
   input  wire logic                clk,
   input  wire logic                rst_n,
   csp_link_if.usr_mp               lnk,
   input  wire logic [DW-1:0]       src_word,
   input  wire logic                src_valid,
   input  wire logic                src_last,
   input  wire logic                src_disc,
   input  wire logic [3:0]          src_tail_words,
   output logic                     src_ready,
   output logic                     req_seen,
   output logic                     req_hint,
   output logic [1:0]               req_hint_kind,
   output logic [7:0]               req_steer
);
   localparam int NK = DW / 32;
   localparam int NB = DW / 8;

   logic [DW-1:0]             word_q;
   logic [CSP_CPL_SIDE_W-1:0] side_q;
   logic [CSP_KEEP_MAX-1:0]   keep_q;
   logic [CSP_KEEP_MAX-1:0]   keep_w;
   logic [CSP_CPL_SIDE_W-1:0] side_w;
   logic                      last_q;
   logic                      valid_q;
   logic                      load_w;
   logic                      first_w;
   logic                      seen_q;
   logic                      hint_q;
   logic [1:0]                kind_q;
   logic [7:0]                steer_q;

   // Skid-free holding stage: load only when empty or just accepted
   assign load_w    = ~valid_q | lnk.cpl_in_ready;
   assign src_ready = load_w;
   assign first_w   = lnk.req_out_valid & lnk.req_out_side[CSP_SOP_BIT];

   genvar gi;
   generate
      for (gi = 0; gi < CSP_KEEP_MAX; gi++)
      begin : g_keep
         // Lanes beyond the width are left high; the device must drop them
         assign keep_w[gi] = (gi >= NK) ||
            (!src_last || src_tail_words == 4'h0 || gi < 32'(src_tail_words));
      end
      for (gi = 0; gi < CSP_CPL_PAR_HI; gi++)
      begin : g_par
         if (gi < NB)
         begin : g_live
            assign side_w[CSP_CPL_PAR_LO+gi] = ~^src_word[gi*8 +: 8];
         end
         else
         begin : g_zero
            assign side_w[CSP_CPL_PAR_LO+gi] = 1'b0;
         end
      end
   endgenerate
   assign side_w[CSP_CPL_DISC_BIT] = src_disc;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         word_q  <= '0;
         side_q  <= '0;
         keep_q  <= '0;
         last_q  <= 1'b0;
         valid_q <= 1'b0;
      end
      else if (load_w)
      begin
         valid_q <= src_valid;
         word_q  <= src_word;
         side_q  <= side_w;
         keep_q  <= keep_w;
         last_q  <= src_last;
      end
   end

   // Request side watched independently of completions in flight
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         seen_q  <= 1'b0;
         hint_q  <= 1'b0;
         kind_q  <= 2'h0;
         steer_q <= 8'h00;
      end
      else
      begin
         seen_q <= first_w;
         if (first_w)
         begin
            hint_q  <= lnk.req_out_side[CSP_HINT_PRES];
            kind_q  <= lnk.req_out_side[CSP_HINT_KIND_HI:CSP_HINT_KIND_LO];
            steer_q <= lnk.req_out_side[CSP_STEER_HI:CSP_STEER_LO];
         end
      end
   end

   assign lnk.cpl_in_word  = word_q;
   assign lnk.cpl_in_side  = side_q;
   assign lnk.cpl_in_keep  = keep_q;
   assign lnk.cpl_in_last  = last_q;
   assign lnk.cpl_in_valid = valid_q;
   assign req_seen         = seen_q;
   assign req_hint         = hint_q;
   assign req_hint_kind    = kind_q;
   assign req_steer        = steer_q;
endmodule : csp_usr_end

// file: testbench/completer_stream_port_tb.sv
// Purpose: random test of both ends of the completer stream port
// Assumes: 64-bit build, so unused parity and keep bits are exercised
// Notes: expectations are queued at drive time, before the design sees them
`timescale 1ns/1ps
module completer_stream_port_tb
   import csp_pkg::*;
;
   localparam int DW = 64;
   logic [DW-1:0] dev_req_word, src_word, out_cpl_word;
   logic          clk, rst_n, quiet, took, rq_in, cp_in, dst;
   logic          dev_req_valid, dev_req_last, dev_req_hint, dev_cpl_space;
   logic          src_valid, src_last, src_disc, src_ready, req_seen, req_hint;
   logic          out_cpl_valid, out_cpl_last, out_cpl_nullify;
   logic [1:0]    dev_req_hint_kind, req_hint_kind;
   logic [7:0]    dev_req_steer, req_steer, out_cpl_keep, kp;
   logic [3:0]    src_tail_words;
   logic [15:0]   lf, r;
   logic [10:0]   e, hq[$];
   logic [73:0]   c, cq[$];
   int            fail_count, total_checks, cyc;
   csp_link_if #(.DW(DW)) lnk_if ();
   csp_dev_end #(.DW(DW)) u_csp_dev_end (.clk, .rst_n, .lnk(lnk_if), .dev_req_word,
      .dev_req_valid, .dev_req_last, .dev_req_hint, .dev_req_hint_kind, .dev_req_steer,
      .dev_cpl_space, .out_cpl_word, .out_cpl_keep, .out_cpl_valid, .out_cpl_last,
      .out_cpl_nullify);
   csp_usr_end #(.DW(DW)) u_csp_usr_end (.clk, .rst_n, .lnk(lnk_if), .src_word, .src_valid,
      .src_last, .src_disc, .src_tail_words, .src_ready, .req_seen, .req_hint,
      .req_hint_kind, .req_steer);
   csp_link_sva #(.DW(DW)) u_csp_link_sva (.clk, .rst_n, .req_out_word(lnk_if.req_out_word),
      .req_out_side(lnk_if.req_out_side), .req_out_valid(lnk_if.req_out_valid),
      .req_out_last(lnk_if.req_out_last), .cpl_in_word(lnk_if.cpl_in_word),
      .cpl_in_side(lnk_if.cpl_in_side), .cpl_in_last(lnk_if.cpl_in_last),
      .cpl_in_keep(lnk_if.cpl_in_keep), .cpl_in_valid(lnk_if.cpl_in_valid),
      .cpl_in_ready(lnk_if.cpl_in_ready));
   function automatic logic [15:0] rnd();
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      return lf;
   endfunction : rnd
   task automatic chk(input string nm, input logic [63:0] ex, input logic [63:0] got);
      total_checks++;
      if (ex !== got)
      begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 4000)
      begin
         fail_count++;
         tally_and_finish();
      end
   end
   initial
   begin
      {rst_n, dev_req_valid, dev_req_last, dev_req_hint, dev_cpl_space} = '0;
      {src_valid, src_last, src_disc, took, rq_in, cp_in, dst} = '0;
      {dev_req_word, src_word, dev_req_hint_kind, dev_req_steer, src_tail_words} = '0;
      lf = 16'h0053;
      repeat (2) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      for (int n = 0; n < 3040; n++)
      begin
         @(negedge clk);
         quiet = n > 3000;
         if (req_seen === 1'b1)
         begin
            e = hq.pop_front();
            chk("req_hint", e[10], req_hint);
            chk("req_hint_kind", e[9:8], req_hint_kind);
            chk("req_steer", e[7:0], req_steer);
         end
         if (out_cpl_valid === 1'b1)
         begin
            c = cq.pop_front();
            chk("cpl_word", c[73:10], out_cpl_word);
            chk("cpl_keep", c[9:2], out_cpl_keep);
            chk("cpl_last", c[1], out_cpl_last);
            chk("cpl_nullify", c[0], out_cpl_nullify);
         end
         // Requests and completions overlap freely, with random back-pressure
         r = rnd();
         dev_cpl_space = r[0] | r[1];
         dev_req_valid = !quiet && r[2];
         dev_req_last = r[3] | r[4];
         dev_req_hint = r[5];
         dev_req_hint_kind = r[7:6];
         dev_req_steer = r[15:8];
         dev_req_word = {rnd(), rnd(), rnd(), rnd()};
         if (dev_req_valid && !rq_in)
            hq.push_back({dev_req_hint, dev_req_hint ? {r[7:6], r[15:8]} : 10'h000});
         if (dev_req_valid)
            rq_in = !dev_req_last;
         // A stalled beat is left untouched; a packet never pauses once begun
         if (!src_valid || took)
         begin
            r = rnd();
            src_valid = cp_in || (!quiet && r[0]);
            src_last = r[1] | r[2];
            src_disc = r[5:3] == 3'h0;
            src_tail_words = (r[7:6] == 2'h3) ? 4'h2 : {2'h0, r[7:6]};
            src_word = {rnd(), rnd(), rnd(), rnd()};
         end
         #1;
         took = src_valid && src_ready;
         if (took)
         begin
            dst = dst | src_disc;
            kp = (src_last && src_tail_words != 4'h0) ? (8'h01 << src_tail_words) - 8'h01
               : (8'h01 << (DW / 32)) - 8'h01;
            cq.push_back({src_word, kp, src_last, src_last & dst});
            cp_in = !src_last;
            dst = dst & !src_last;
         end
      end
      chk("cpl_left", 64'h0, cq.size());
      chk("req_left", 64'h0, hq.size());
      tally_and_finish();
   end
endmodule : completer_stream_port_tb

// file: testbench/csp_link_sva.sv
// Purpose: link checks for the completer stream port
// Assumes: one clock, asynchronous active-low reset
// Notes: parity is rebuilt from the data words, so a wrong byte order shows
`timescale 1ns/1ps
module csp_link_sva
   import csp_pkg::*;
#(
   parameter int DW = CSP_DW_DEFAULT
)(
   input wire logic                      clk,
   input wire logic                      rst_n,
   input wire logic [DW-1:0]             req_out_word,
   input wire logic [CSP_REQ_SIDE_W-1:0] req_out_side,
   input wire logic                      req_out_valid,
   input wire logic                      req_out_last,
   input wire logic [DW-1:0]             cpl_in_word,
   input wire logic [CSP_CPL_SIDE_W-1:0] cpl_in_side,
   input wire logic                      cpl_in_last,
   input wire logic [CSP_KEEP_MAX-1:0]   cpl_in_keep,
   input wire logic                      cpl_in_valid,
   input wire logic                      cpl_in_ready
);
   function automatic logic [CSP_PAR_W-1:0] par_f(input logic [DW-1:0] w);
      logic [CSP_PAR_W-1:0] p;
      p = '0;
      for (int i = 0; i < DW / 8; i++)
         p[i] = ~^w[8*i +: 8];
      return p;
   endfunction : par_f
   wire logic [CSP_PAR_W-1:0] req_par = par_f(req_out_word);
   wire logic [CSP_PAR_W-1:0] cpl_par = par_f(cpl_in_word);
   logic                      in_pkt_q;
   // Tracks packet framing so the start flag can be judged beat by beat
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         in_pkt_q <= 1'b0;
      else if (req_out_valid)
         in_pkt_q <= !req_out_last;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_req_par; req_out_valid |-> req_out_side[CSP_PAR_HI:CSP_PAR_LO] == req_par; endproperty
   a_req_par: assert property (p_req_par) else $error("request parity wrong");
   property p_par_zero; (req_out_side[CSP_PAR_HI:CSP_PAR_LO] >> (DW / 8)) == '0; endproperty
   a_par_zero: assert property (p_par_zero) else $error("unused parity set");
   property p_sop; req_out_valid |-> req_out_side[CSP_SOP_BIT] == !in_pkt_q; endproperty
   a_sop: assert property (p_sop) else $error("start flag wrong");
   property p_hint_first; req_out_side[CSP_HINT_PRES]
      |-> req_out_valid && req_out_side[CSP_SOP_BIT]; endproperty
   a_hint_first: assert property (p_hint_first) else $error("hint flag off first beat");
   property p_nohint; req_out_valid && req_out_side[CSP_SOP_BIT] && !req_out_side[CSP_HINT_PRES]
      |-> req_out_side[CSP_STEER_HI:CSP_HINT_KIND_LO] == '0; endproperty
   a_nohint: assert property (p_nohint) else $error("hint fields without hint");
   property p_hold; cpl_in_valid && !cpl_in_ready |=> cpl_in_valid && $stable(cpl_in_word)
      && $stable(cpl_in_side) && $stable(cpl_in_last) && $stable(cpl_in_keep); endproperty
   a_hold: assert property (p_hold) else $error("beat changed while stalled");
   property p_run; cpl_in_valid && cpl_in_ready && !cpl_in_last |=> cpl_in_valid; endproperty
   a_run: assert property (p_run) else $error("valid dropped in packet");
   property p_cpl_par; cpl_in_valid |-> cpl_in_side[CSP_CPL_PAR_HI:CSP_CPL_PAR_LO] == cpl_par;
   endproperty
   a_cpl_par: assert property (p_cpl_par) else $error("completion parity wrong");
   property p_keep; cpl_in_valid && !cpl_in_last |-> &cpl_in_keep[DW/32-1:0]; endproperty
   a_keep: assert property (p_keep) else $error("keep not full");
   c_hint: cover property (req_out_valid && req_out_side[CSP_HINT_PRES]);
   c_stall: cover property (cpl_in_valid && !cpl_in_ready);
   c_disc: cover property (cpl_in_valid && cpl_in_ready && cpl_in_side[CSP_CPL_DISC_BIT]);
endmodule : csp_link_sva
